/* File: src/aoc_defines.vh */
// register map, field positions, reset values and pattern codes of the config bank
`ifndef AOC_DEFINES_VH
`define AOC_DEFINES_VH

`define AOC_ADDR_PORT_CFG   13'h000
`define AOC_ADDR_CHIP_ID    13'h001
`define AOC_ADDR_CHIP_GRADE 13'h002
`define AOC_ADDR_INDEX_2    13'h004
`define AOC_ADDR_INDEX_1    13'h005
`define AOC_ADDR_CLK_DIV    13'h00b
`define AOC_ADDR_CHOP       13'h00c
`define AOC_ADDR_TEST_SEL   13'h00d
`define AOC_ADDR_OFFSET     13'h010
`define AOC_ADDR_OUT_FMT    13'h014

`define AOC_RST_PORT_CFG    8'h18
`define AOC_RST_INDEX_2     4'hf
`define AOC_RST_INDEX_1     6'h3f
`define AOC_RST_CLK_DIV     3'h0
`define AOC_RST_TEST_SEL    8'h00
`define AOC_RST_OFFSET      8'h00
`define AOC_RST_OUT_FMT     8'h01

`define AOC_PORT_SRST_HI    5
`define AOC_PORT_SRST_LO    2
`define AOC_CHOP_BIT        2
`define AOC_FMT_TWOS_BIT    0
`define AOC_FMT_INV_BIT     2
`define AOC_FMT_IEEE_BIT    6
`define AOC_TS_LONG_RST_BIT 5
`define AOC_TS_SHRT_RST_BIT 4

`define AOC_TM_OFF          4'h0
`define AOC_TM_MIDSCALE     4'h1
`define AOC_TM_POS_FULL     4'h2
`define AOC_TM_NEG_FULL     4'h3
`define AOC_TM_CHECKER      4'h4
`define AOC_TM_PN_LONG      4'h5
`define AOC_TM_PN_SHORT     4'h6
`define AOC_TM_WORD_TOGGLE  4'h7
`define AOC_TM_USER         4'h8
`define AOC_TM_BIT_TOGGLE   4'h9
`define AOC_TM_SYNC         4'ha
`define AOC_TM_ONE_BIT      4'hb
`define AOC_TM_MIXED        4'hc

`define AOC_US_SINGLE       2'h0
`define AOC_US_ALT          2'h1
`define AOC_US_SINGLE_ONCE  2'h2
`define AOC_US_ALT_ONCE     2'h3

`define AOC_WORD_MID        12'h800
`define AOC_WORD_ONES       12'hfff
`define AOC_WORD_ZEROS      12'h000
`define AOC_WORD_CHK_A      12'haaa
`define AOC_WORD_CHK_B      12'h555
`define AOC_WORD_SYNC       12'h03f
`define AOC_WORD_MIXED      12'ha33

`endif

/* File: src/aoc_pattern_gen.v */
// one channel of output test pattern generation and data formatting
`timescale 1ns/100ps
`default_nettype none
`include "aoc_defines.vh"

module aoc_pattern_gen (
  // clock and reset
  input  wire        ref_clk_i,
  input  wire        rst_n_i,
  // sample timing
  input  wire        sample_en_i,
  // configuration
  input  wire [3:0]  test_sel_i,
  input  wire [1:0]  user_seq_i,
  input  wire        pn_long_rst_i,
  input  wire        pn_short_rst_i,
  input  wire        invert_i,
  input  wire        twos_i,
  input  wire [7:0]  offset_i,
  // data
  input  wire [11:0] conv_i,
  input  wire [11:0] user_a_i,
  input  wire [11:0] user_b_i,
  output reg  [11:0] data_o
);

  reg  [22:0] pn_long_q;
  reg  [8:0]  pn_short_q;
  reg         toggle_q;
  reg  [1:0]  user_cnt_q;
  reg  [11:0] word_d;
  reg  [11:0] user_w;
  wire [11:0] trimmed;

  assign trimmed = conv_i + {{4{offset_i[7]}}, offset_i};

  // ----------------------------------------------------------------
  // sequence state
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pn_long_q  <= 23'h7fffff;
      pn_short_q <= 9'h1ff;
      toggle_q   <= 1'b0;
      user_cnt_q <= 2'h0;
    end else begin
      // [R7] generator restarts
      if (pn_long_rst_i) begin
        pn_long_q <= 23'h7fffff;
      end else if (sample_en_i) begin
        // [R3] order 23 sequence
        pn_long_q <= {pn_long_q[21:0], pn_long_q[22] ^ pn_long_q[17]};
      end
      if (pn_short_rst_i) begin
        pn_short_q <= 9'h1ff;
      end else if (sample_en_i) begin
        // [R4] order 9 sequence
        pn_short_q <= {pn_short_q[7:0], pn_short_q[8] ^ pn_short_q[4]};
      end
      if (sample_en_i) begin
        toggle_q <= ~toggle_q;
      end
      if (test_sel_i != `AOC_TM_USER) begin
        user_cnt_q <= 2'h0;
      end else if (sample_en_i && user_cnt_q != 2'h3) begin
        user_cnt_q <= user_cnt_q + 2'h1;
      end
    end
  end

  // [R7] user pattern sequencing
  always @* begin
    case (user_seq_i)
      `AOC_US_SINGLE:      user_w = user_a_i;
      `AOC_US_ALT:         user_w = toggle_q ? user_b_i : user_a_i;
      `AOC_US_SINGLE_ONCE: user_w = (user_cnt_q == 2'h0) ? user_a_i : `AOC_WORD_ZEROS;
      `AOC_US_ALT_ONCE:    user_w = (user_cnt_q == 2'h0) ? user_a_i :
                                    (user_cnt_q == 2'h1) ? user_b_i : `AOC_WORD_ZEROS;
      default:             user_w = user_a_i;
    endcase
  end

  // ----------------------------------------------------------------
  // pattern select
  // ----------------------------------------------------------------
  always @* begin
    case (test_sel_i)
      // [R2]-[R4] normal data, fixed words and pseudorandom sequences
      `AOC_TM_OFF:         word_d = {trimmed[11] ^ twos_i, trimmed[10:0]};
      `AOC_TM_MIDSCALE:    word_d = `AOC_WORD_MID;
      `AOC_TM_POS_FULL:    word_d = `AOC_WORD_ONES;
      `AOC_TM_NEG_FULL:    word_d = `AOC_WORD_ZEROS;
      `AOC_TM_CHECKER:     word_d = toggle_q ? `AOC_WORD_CHK_B : `AOC_WORD_CHK_A;
      `AOC_TM_PN_LONG:     word_d = pn_long_q[11:0];
      `AOC_TM_PN_SHORT:    word_d = {pn_short_q[8:0], 3'h0};
      // [R5] ones and zeros words
      `AOC_TM_WORD_TOGGLE: word_d = toggle_q ? `AOC_WORD_ZEROS : `AOC_WORD_ONES;
      // [R6] further patterns
      `AOC_TM_USER:        word_d = user_w;
      `AOC_TM_BIT_TOGGLE:  word_d = `AOC_WORD_CHK_A;
      `AOC_TM_SYNC:        word_d = `AOC_WORD_SYNC;
      `AOC_TM_ONE_BIT:     word_d = `AOC_WORD_MID;
      `AOC_TM_MIXED:       word_d = `AOC_WORD_MIXED;
      default:             word_d = `AOC_WORD_ZEROS;
    endcase
  end

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_o <= 12'h000;
    end else if (sample_en_i) begin
      data_o <= invert_i ? ~word_d : word_d;
    end
  end

endmodule
`default_nettype wire

/* File: src/aoc_config_bank.v */
// serial configured clock divider, test pattern and output format bank, eight channels
// Contract
// [R1] sample clock divided by the 3-bit ratio field plus one, 1 to 8.
// [R2] per-channel 4-bit selector; 0000 data, 0001-0100 fixed midscale, full scale, checkerboard.
// [R3] selector 0101 drives the order-23 long pseudorandom sequence.
// [R4] selector 0110 drives the order-9 short pseudorandom sequence.
// [R5] selector 0111 alternates all-ones and all-zeros words per sample.
// [R6] codes 1000-1100: user, bit toggle, sync, one bit high, mixed frequency.
// [R7] 2-bit user sequencing in user mode; two bits restart the generators.
// [R8] per-channel writes reach only channels selected in both index registers; the code takes channels 7-4 from index 2 and 3-0 from index 1 bits 3:0.
// [R9] read with several channels selected returns the first selected channel.
// [R10] soft reset bit restores all registers to defaults and clears itself.
`timescale 1ns/100ps
`default_nettype none
`include "aoc_defines.vh"

module aoc_config_bank #(
  parameter [7:0] CHIP_ID    = 8'h5a,  // arbitrary value
  parameter [7:0] CHIP_GRADE = 8'h00   // arbitrary value
) (
  // clock and reset
  input  wire        ref_clk_i,
  input  wire        rst_n_i,
  // serial configuration port
  input  wire        spi_sclk_i,
  input  wire        spi_csb_n_i,
  input  wire        spi_sdio_i,
  output reg         spi_sdio_o,
  output reg         spi_sdio_oe_o,
  // conversion data and user words
  input  wire [95:0] conv_i,
  input  wire [11:0] user_a_i,
  input  wire [11:0] user_b_i,
  // outputs
  output reg         sample_en_o,
  output wire [95:0] data_o,
  output reg         chop_en_o,
  output reg         lvds_reduced_o
);

  localparam ST_IDLE  = 2'h0;
  localparam ST_INSTR = 2'h1;
  localparam ST_DATA  = 2'h2;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  reg [1:0] sclk_s_q;
  reg [1:0] csb_s_q;
  reg [1:0] sdio_s_q;
  reg       sclk_d1_q;
  wire      sclk_rise = sclk_s_q[1] & ~sclk_d1_q;
  wire      sclk_fall = ~sclk_s_q[1] & sclk_d1_q;

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_s_q  <= 2'h0;
      csb_s_q   <= 2'h3;
      sdio_s_q  <= 2'h0;
      sclk_d1_q <= 1'b0;
    end else begin
      sclk_s_q  <= {sclk_s_q[0], spi_sclk_i};
      csb_s_q   <= {csb_s_q[0], spi_csb_n_i};
      sdio_s_q  <= {sdio_s_q[0], spi_sdio_i};
      sclk_d1_q <= sclk_s_q[1];
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [7:0]  port_cfg_q;
  reg [3:0]  index2_q;
  reg [5:0]  index1_q;
  reg [2:0]  clk_div_q;
  reg        chop_q;
  reg [1:0]  pn_rst_q;
  reg [7:0]  out_fmt_q;
  reg [63:0] test_sel_q;
  reg [63:0] offset_q;
  reg [7:0]  invert_q;

  // serial engine state
  reg [1:0]  state_q;
  reg [3:0]  bit_cnt_q;
  reg [15:0] instr_q;
  reg [12:0] addr_q;
  reg [7:0]  wr_sh_q;
  reg        load_q;
  reg        skip_q;
  reg [7:0]  rd_sh_q;

  wire       is_read  = instr_q[15];
  wire [7:0] wr_byte  = {wr_sh_q[6:0], sdio_s_q[1]};
  wire [7:0] chan_sel = {index2_q, index1_q[3:0]};
  wire       byte_end = (state_q == ST_DATA) && sclk_rise && (bit_cnt_q == 4'h7);
  wire       wr_now   = byte_end && !is_read;

  // [R9] first selected channel answers reads
  reg [2:0] rd_ch;
  integer   k;
  always @* begin
    rd_ch = 3'h0;
    for (k = 7; k >= 0; k = k - 1) begin
      if (chan_sel[k]) begin
        rd_ch = k[2:0];
      end
    end
  end

  reg [7:0] rd_data;
  always @* begin
    case (addr_q)
      `AOC_ADDR_PORT_CFG:   rd_data = port_cfg_q;
      `AOC_ADDR_CHIP_ID:    rd_data = CHIP_ID;
      `AOC_ADDR_CHIP_GRADE: rd_data = CHIP_GRADE;
      `AOC_ADDR_INDEX_2:    rd_data = {4'h0, index2_q};
      `AOC_ADDR_INDEX_1:    rd_data = {2'h0, index1_q};
      `AOC_ADDR_CLK_DIV:    rd_data = {5'h00, clk_div_q};
      `AOC_ADDR_CHOP:       rd_data = {5'h00, chop_q, 2'h0};
      `AOC_ADDR_TEST_SEL:   rd_data = {test_sel_q[rd_ch*8+7 -: 2], pn_rst_q,
                                       test_sel_q[rd_ch*8+3 -: 4]};
      `AOC_ADDR_OFFSET:     rd_data = offset_q[rd_ch*8 +: 8];
      `AOC_ADDR_OUT_FMT:    rd_data = {1'b0, out_fmt_q[6], 3'h0, invert_q[rd_ch],
                                       1'b0, out_fmt_q[0]};
      default:              rd_data = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // serial protocol engine
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q       <= ST_IDLE;
      bit_cnt_q     <= 4'h0;
      instr_q       <= 16'h0000;
      addr_q        <= 13'h0000;
      wr_sh_q       <= 8'h00;
      load_q        <= 1'b0;
      skip_q        <= 1'b0;
      rd_sh_q       <= 8'h00;
      spi_sdio_o    <= 1'b0;
      spi_sdio_oe_o <= 1'b0;
    end else if (csb_s_q[1]) begin
      state_q       <= ST_INSTR;
      bit_cnt_q     <= 4'h0;
      load_q        <= 1'b0;
      skip_q        <= 1'b0;
      spi_sdio_oe_o <= 1'b0;
    end else begin
      load_q <= 1'b0;
      if (load_q) begin
        rd_sh_q       <= rd_data;
        spi_sdio_o    <= rd_data[7];
        spi_sdio_oe_o <= 1'b1;
        skip_q        <= 1'b1;
      end
      if (sclk_fall && spi_sdio_oe_o) begin
        if (skip_q) begin
          skip_q <= 1'b0;
        end else begin
          spi_sdio_o <= rd_sh_q[6];
          rd_sh_q    <= {rd_sh_q[6:0], 1'b0};
        end
      end
      case (state_q)
        ST_INSTR: begin
          if (sclk_rise) begin
            instr_q   <= {instr_q[14:0], sdio_s_q[1]};
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q == 4'hf) begin
              state_q   <= ST_DATA;
              bit_cnt_q <= 4'h0;
              addr_q    <= {instr_q[11:0], sdio_s_q[1]};
              load_q    <= instr_q[14];
            end
          end
        end
        ST_DATA: begin
          if (sclk_rise) begin
            wr_sh_q   <= wr_byte;
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q == 4'h7) begin
              bit_cnt_q <= 4'h0;
              addr_q    <= addr_q - 13'h0001;
              load_q    <= is_read;
            end
          end
        end
        ST_IDLE: begin
          state_q <= ST_INSTR;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  wire soft_rst = wr_now && (addr_q == `AOC_ADDR_PORT_CFG) &&
                  (wr_byte[`AOC_PORT_SRST_HI] || wr_byte[`AOC_PORT_SRST_LO]);
  integer c;

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_cfg_q <= `AOC_RST_PORT_CFG;
      index2_q   <= `AOC_RST_INDEX_2;
      index1_q   <= `AOC_RST_INDEX_1;
      clk_div_q  <= `AOC_RST_CLK_DIV;
      chop_q     <= 1'b0;
      pn_rst_q   <= 2'h0;
      out_fmt_q  <= `AOC_RST_OUT_FMT;
      test_sel_q <= {8{`AOC_RST_TEST_SEL}};
      offset_q   <= {8{`AOC_RST_OFFSET}};
      invert_q   <= 8'h00;
    end else if (soft_rst) begin
      // [R10] soft reset restores defaults, bit self clears
      port_cfg_q <= `AOC_RST_PORT_CFG;
      index2_q   <= `AOC_RST_INDEX_2;
      index1_q   <= `AOC_RST_INDEX_1;
      clk_div_q  <= `AOC_RST_CLK_DIV;
      chop_q     <= 1'b0;
      pn_rst_q   <= 2'h0;
      out_fmt_q  <= `AOC_RST_OUT_FMT;
      test_sel_q <= {8{`AOC_RST_TEST_SEL}};
      offset_q   <= {8{`AOC_RST_OFFSET}};
      invert_q   <= 8'h00;
    end else if (wr_now) begin
      case (addr_q)
        `AOC_ADDR_PORT_CFG: port_cfg_q <= {1'b0, wr_byte[6], 4'h3, wr_byte[1], 1'b0};
        `AOC_ADDR_INDEX_2:  index2_q   <= wr_byte[3:0];
        `AOC_ADDR_INDEX_1:  index1_q   <= wr_byte[5:0];
        `AOC_ADDR_CLK_DIV:  clk_div_q  <= wr_byte[2:0];
        `AOC_ADDR_CHOP:     chop_q     <= wr_byte[`AOC_CHOP_BIT];
        `AOC_ADDR_TEST_SEL: pn_rst_q   <= {wr_byte[`AOC_TS_LONG_RST_BIT],
                                           wr_byte[`AOC_TS_SHRT_RST_BIT]};
        `AOC_ADDR_OUT_FMT:  out_fmt_q  <= {1'b0, wr_byte[`AOC_FMT_IEEE_BIT], 5'h00,
                                           wr_byte[`AOC_FMT_TWOS_BIT]};
        default:            port_cfg_q <= port_cfg_q;
      endcase
      // [R8] local writes follow the channel index bits
      for (c = 0; c < 8; c = c + 1) begin
        if (chan_sel[c]) begin
          if (addr_q == `AOC_ADDR_TEST_SEL) begin
            test_sel_q[c*8 +: 8] <= {wr_byte[7:6], 2'h0, wr_byte[3:0]};
          end
          if (addr_q == `AOC_ADDR_OFFSET) begin
            offset_q[c*8 +: 8] <= wr_byte;
          end
          if (addr_q == `AOC_ADDR_OUT_FMT) begin
            invert_q[c] <= wr_byte[`AOC_FMT_INV_BIT];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // sample clock divider and global outputs
  // ----------------------------------------------------------------
  reg [2:0] div_cnt_q;

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_cnt_q      <= 3'h0;
      sample_en_o    <= 1'b0;
      chop_en_o      <= 1'b0;
      lvds_reduced_o <= 1'b0;
    end else begin
      // [R1] divide by ratio plus one
      if (div_cnt_q >= clk_div_q) begin
        div_cnt_q   <= 3'h0;
        sample_en_o <= 1'b1;
      end else begin
        div_cnt_q   <= div_cnt_q + 3'h1;
        sample_en_o <= 1'b0;
      end
      chop_en_o      <= chop_q;
      lvds_reduced_o <= out_fmt_q[`AOC_FMT_IEEE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // per-channel pattern generators
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_chan
      aoc_pattern_gen u_gen (
        .ref_clk_i      (ref_clk_i),
        .rst_n_i        (rst_n_i),
        .sample_en_i    (sample_en_o),
        .test_sel_i     (test_sel_q[g*8 +: 4]),
        .user_seq_i     (test_sel_q[g*8+6 +: 2]),
        .pn_long_rst_i  (pn_rst_q[1]),
        .pn_short_rst_i (pn_rst_q[0]),
        .invert_i       (invert_q[g]),
        .twos_i         (out_fmt_q[`AOC_FMT_TWOS_BIT]),
        .offset_i       (offset_q[g*8 +: 8]),
        .conv_i         (conv_i[g*12 +: 12]),
        .user_a_i       (user_a_i),
        .user_b_i       (user_b_i),
        .data_o         (data_o[g*12 +: 12])
      );
    end
  endgenerate

endmodule
`default_nettype wire

/* File: sim/aoc_config_bank_sva.sv */
// port level assertions for the configuration bank
`timescale 1ns/100ps
`default_nettype none
module aoc_config_bank_sva (
  // clock and reset
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  // serial port
  input wire logic        spi_sclk_i,
  input wire logic        spi_csb_n_i,
  input wire logic        spi_sdio_o,
  input wire logic        spi_sdio_oe_o,
  // outputs
  input wire logic        sample_en_o,
  input wire logic [95:0] data_o,
  input wire logic        chop_en_o,
  input wire logic        lvds_reduced_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_SE_PERIOD:
    assert property (sample_en_o |=> ##[0:7] sample_en_o) else $error("sample gap above 8");
  AST_DATA_HOLD:
    assert property (!$past(sample_en_o) |-> $stable(data_o)) else $error("data moved off sample");
  AST_OE_IDLE:
    assert property (spi_csb_n_i [*5] |-> !spi_sdio_oe_o) else $error("sdio driven while idle");
  AST_OE_RISE:
    assert property ($rose(spi_sdio_oe_o) |-> !spi_csb_n_i && !$past(spi_csb_n_i, 4))
      else $error("sdio enable without frame");
  AST_OE_HOLD:
    assert property (spi_sdio_oe_o && !spi_csb_n_i |=> spi_sdio_oe_o) else $error("sdio dropped");
  AST_SDIO_SHIFT:
    assert property ($rose(spi_sclk_i) && spi_sdio_oe_o
      |-> $stable(spi_sdio_o) && $past(spi_sdio_oe_o, 2)) else $error("read bit moved at sclk rise");
  AST_CHOP_WRITE:
    assert property ($changed(chop_en_o) |-> !$past(spi_csb_n_i, 2)) else $error("chop moved");
  AST_LVDS_WRITE:
    assert property ($changed(lvds_reduced_o) |-> !$past(spi_csb_n_i, 2)) else $error("lvds moved");
  cover property (sample_en_o ##1 !sample_en_o);
  cover property ($rose(spi_sdio_oe_o));
  cover property ($rose(chop_en_o));
endmodule
`default_nettype wire

/* File: sim/aoc_host_model.sv */
// host controller model driving the three-wire configuration port
`timescale 1ns/100ps
`default_nettype none
module aoc_host_model (
  input  wire logic ref_clk_i,
  input  wire logic sdio_i,
  output var  logic sclk_o,
  output var  logic csb_n_o,
  output var  logic sdio_o
);
  initial begin
    sclk_o = 1'b0;
    csb_n_o = 1'b1;
    sdio_o = 1'b0;
  end
  // sclk phases kept at five ref clocks each
  task automatic half();
    repeat (5) @(negedge ref_clk_i);
  endtask
  // one byte per frame, msb first
  task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] wd,
                      output logic [7:0] rdat);
    logic [23:0] sh;
    sh = {rd, 2'b00, a, wd};
    rdat = 8'h00;
    csb_n_o = 1'b0;
    half();
    for (int i = 23; i >= 0; i--) begin
      sclk_o = 1'b0;
      // released line toggles so a stale level is never seen
      if (rd && i < 8) sdio_o = ~sdio_o;
      else sdio_o = sh[i];
      half();
      if (i < 8) rdat[i] = sdio_i;
      sclk_o = 1'b1;
      half();
    end
    sclk_o = 1'b0;
    half();
    csb_n_o = 1'b1;
    half();
  endtask
endmodule
`default_nettype wire

/* File: sim/aoc_config_bank_test.sv */
// self-checking bench for the configuration bank
`timescale 1ns/100ps
`default_nettype none
module aoc_config_bank_test;
  logic        ref_clk_i;
  logic        rst_n_i;
  logic        sclk, csb_n, host_sdio, sdio_o, sdio_oe;
  logic        sample_en, chop_en, lvds_red;
  logic [95:0] conv, data;
  logic [11:0] user_a, user_b, w0, w1;
  int          errors, num_checks;
  wire         sdio_w = sdio_oe ? sdio_o : host_sdio;
  localparam logic [12:0] RA [9] = '{13'h000, 13'h004, 13'h005, 13'h00b, 13'h00c,
                                     13'h00d, 13'h010, 13'h014, 13'h030};
  localparam logic [7:0]  RV [9] = '{8'h18, 8'h0f, 8'h3f, 0, 0, 0, 0, 8'h01, 0};
  localparam logic [3:0]  TC [9] = '{1, 2, 3, 9, 10, 11, 12, 4, 7};
  localparam logic [11:0] TW [9] = '{12'h800, 12'hfff, 0, 12'haaa, 12'h03f, 12'h800,
                                     12'ha33, 12'haaa, 12'hfff};
  localparam logic [11:0] TX [9] = '{12'h800, 12'hfff, 0, 12'haaa, 12'h03f, 12'h800,
                                     12'ha33, 12'h555, 12'h000};

  aoc_config_bank aoc_config_bank_i (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .spi_sclk_i(sclk), .spi_csb_n_i(csb_n),
    .spi_sdio_i(sdio_w), .spi_sdio_o(sdio_o), .spi_sdio_oe_o(sdio_oe), .conv_i(conv),
    .user_a_i(user_a), .user_b_i(user_b), .sample_en_o(sample_en), .data_o(data),
    .chop_en_o(chop_en), .lvds_reduced_o(lvds_red));
  aoc_host_model aoc_host_model_i (
    .ref_clk_i(ref_clk_i), .sdio_i(sdio_w), .sclk_o(sclk), .csb_n_o(csb_n),
    .sdio_o(host_sdio));

  always #4 ref_clk_i = ~ref_clk_i;

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_word(input string what, input logic [11:0] exp, input logic [11:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] unused;
    aoc_host_model_i.xfer(1'b0, a, d, unused);
  endtask
  task automatic rd(input logic [12:0] a, output logic [7:0] d);
    aoc_host_model_i.xfer(1'b1, a, 8'h00, d);
  endtask
  task automatic settle();
    repeat (6) @(negedge ref_clk_i);
  endtask
  task automatic pair(input int lo);
    settle();
    w0 = data[lo +: 12];
    @(negedge ref_clk_i);
    w1 = data[lo +: 12];
  endtask
  task automatic wait_se();
    int k;
    k = 0;
    do begin
      @(negedge ref_clk_i);
      k++;
    end while (sample_en !== 1'b1 && k < 20);
    if (k >= 20) begin
      errors++;
      conclude();
    end
  endtask

  task automatic t_regs();
    logic [7:0] d;
    for (int i = 0; i < 9; i++) begin
      rd(RA[i], d);
      chk_reg("reset value", RV[i], d);
    end
    $display("t_regs done");
  endtask
  task automatic t_div();
    logic [7:0] n;
    for (int r = 0; r < 8; r++) begin
      wr(13'h00b, 8'(r));
      wait_se();
      wait_se();
      n = 0;
      do begin
        @(negedge ref_clk_i);
        n++;
      end while (sample_en !== 1'b1 && n < 8'd20);
      chk_reg("divide period", 8'(r + 1), n);
      if (n >= 8'd20)
        conclude();
    end
    wr(13'h00b, 8'h00);
    $display("t_div done");
  endtask
  task automatic t_pat();
    for (int i = 0; i < 9; i++) begin
      wr(13'h00d, {4'h0, TC[i]});
      pair(24);
      chk_word("pattern pair", TW[i] ^ TX[i], w0 ^ w1);
      chk_word("pattern word", (w0 === TX[i]) ? TX[i] : TW[i], w0);
    end
    $display("t_pat done");
  endtask
  task automatic t_norm();
    wr(13'h00d, 8'h00);
    settle();
    chk_word("twos data", 12'h923, data[11:0]);
    wr(13'h014, 8'h00);
    wr(13'h010, 8'h05);
    settle();
    chk_word("offset data", 12'h128, data[11:0]);
    wr(13'h014, 8'h04);
    settle();
    chk_word("inverted data", 12'hed7, data[11:0]);
    wr(13'h010, 8'h00);
    wr(13'h014, 8'h01);
    $display("t_norm done");
  endtask
  task automatic t_pn();
    wr(13'h00d, 8'h16);
    pair(0);
    chk_word("short seed", 12'hff8, w1);
    wr(13'h00d, 8'h06);
    repeat (40) @(negedge ref_clk_i);
    chk_reg("short runs", 8'h01, {7'h0, data[11:0] != 12'hff8});
    wr(13'h00d, 8'h25);
    pair(0);
    chk_word("long seed", 12'hfff, w1);
    wr(13'h00d, 8'h05);
    repeat (40) @(negedge ref_clk_i);
    chk_reg("long runs", 8'h01, {7'h0, data[11:0] != 12'hfff});
    $display("t_pn done");
  endtask
  task automatic t_user();
    wr(13'h00d, 8'h48);
    pair(0);
    chk_word("user alternate", 12'h3c3 ^ 12'h0f0, w0 ^ w1);
    wr(13'h00d, 8'h08);
    pair(0);
    chk_word("user repeat", 12'h3c3, w0 & w1);
    wr(13'h00d, 8'h00);
    wr(13'h00d, 8'h88);
    settle();
    chk_word("user once", 12'h000, data[11:0]);
    wr(13'h00d, 8'h00);
    wr(13'h00d, 8'hc8);
    settle();
    chk_word("user alternate once", 12'h000, data[11:0]);
    $display("t_user done");
  endtask
  task automatic t_index();
    logic [7:0] d;
    wr(13'h00d, 8'h00);
    wr(13'h004, 8'h00);
    wr(13'h005, 8'h02);
    wr(13'h00d, 8'h02);
    settle();
    chk_word("chan b", 12'hfff, data[23:12]);
    chk_word("chan a", 12'h923, data[11:0]);
    rd(13'h00d, d);
    chk_reg("read b", 8'h02, d);
    wr(13'h005, 8'h03);
    rd(13'h00d, d);
    chk_reg("read first", 8'h00, d);
    $display("t_index done");
  endtask
  task automatic t_srst();
    logic [7:0] d;
    wr(13'h00c, 8'h04);
    wr(13'h014, 8'h41);
    wr(13'h00b, 8'h03);
    chk_reg("chop on", 8'h01, {7'h0, chop_en});
    chk_reg("lvds on", 8'h01, {7'h0, lvds_red});
    wr(13'h000, 8'h24);
    chk_reg("chop off", 8'h00, {7'h0, chop_en});
    chk_reg("lvds off", 8'h00, {7'h0, lvds_red});
    for (int i = 0; i < 9; i++) begin
      rd(RA[i], d);
      chk_reg("after soft reset", RV[i], d);
    end
    $display("t_srst done");
  endtask

  initial begin
    ref_clk_i = 1'b0;
    rst_n_i = 1'b0;
    errors = 0;
    num_checks = 0;
    conv = {84'h0, 12'h123};
    user_a = 12'h3c3;
    user_b = 12'h0f0;
    repeat (4) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    t_regs();
    t_div();
    t_pat();
    t_norm();
    t_pn();
    t_user();
    t_index();
    t_srst();
    conclude();
  end
endmodule

bind aoc_config_bank aoc_config_bank_sva aoc_config_bank_sva_i (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .spi_sclk_i(spi_sclk_i),
  .spi_csb_n_i(spi_csb_n_i), .spi_sdio_o(spi_sdio_o), .spi_sdio_oe_o(spi_sdio_oe_o),
  .sample_en_o(sample_en_o), .data_o(data_o), .chop_en_o(chop_en_o),
  .lvds_reduced_o(lvds_reduced_o));
`default_nettype wire
